/* File: core/srr_cfg.svh */
// constants of the stop recovery and debug reset sequencer
// assumes a 200 MHz aclk and AXI4-Lite register access
// Overview of operation
// - a one written to the debug reset request bit starts a full system reset
// - the debug unit keeps its state; everything else takes the system reset
// - hardware clears the debug reset request bit once the reset is underway
// - the power-on flag reads set after a debug reset completes
// - wake-up holds the core 66 watchdog-oscillator then 16 system-clock cycles
// - stop recovery changes only watchdog control flags; all other state is kept (the code also sets interrupt status bit 0)
// - after recovery the core loads the vector from bytes 0002H and 0003H
// - every stop wake-up sets the stop-recovery flag
// - watchdog time-out wakes stop; its interrupt follows recovery when enabled
// - a watchdog wake-up sets both watchdog-timeout and stop-recovery flags
// - an enabled pin changing level either way wakes the device
// - the port input sample register does not capture while in stop
// - a pin level is captured only if it lasts past the recovery delay
`ifndef SRR_CFG_SVH
`define SRR_CFG_SVH

// register offsets, byte addresses
`define SRR_OFF_CTRL 8'h00
`define SRR_OFF_WCTL 8'h04
`define SRR_OFF_ISTAT 8'h08
`define SRR_OFF_IMASK 8'h0C
`define SRR_OFF_WAKE_EN 8'h10
`define SRR_OFF_PORT_IN 8'h14
`define SRR_OFF_STATE 8'h18

// field positions
`define SRR_CTRL_RST 0
`define SRR_WCTL_POR 0
`define SRR_WCTL_STOP 1
`define SRR_WCTL_WDT 2
`define SRR_IRQ_WAKE 0
`define SRR_IRQ_DBG 1
`define SRR_IRQ_PIN 2

// reset values
`define SRR_WCTL_RST 3'h0
`define SRR_IMASK_RST 3'h0
`define SRR_WAKE_EN_RST 1'b0
`define SRR_VEC_ADDR 16'h0002

// timing
`define SRR_WDO_CYCLES 7'h42
`define SRR_SYS_CYCLES 7'h10
`define SRR_CLK_HZ 200000000
`define SRR_WDO_HZ 10000

`endif

/* File: core/srr_pkg.sv */
// types of the stop recovery and debug reset sequencer
// assumes nothing beyond the sequencer itself
package srr_pkg;

    // sequencer states
    typedef enum logic [1:0] {SRR_RUN, SRR_STOP, SRR_HOLD_WDO, SRR_HOLD_SYS} srr_state_t;

endpackage

/* File: core/srr_cnt_if.sv */
// control bundle between the sequencer and one hold counter
// assumes both ends run on aclk
`timescale 1ns/100ps
interface srr_cnt_if #(parameter int W = 7);
    logic load;
    logic [W-1:0] init;
    logic en;
    logic done;
    modport ctl (output load, output init, output en, input done);
    modport cnt (input load, input init, input en, output done);
endinterface

/* File: core/srr_cnt.sv */
// loadable down counter for one phase of the reset hold
// assumes a synchronous active-low reset on aclk
`timescale 1ns/100ps
module srr_cnt #(parameter int W = 7)
(
    input wire logic aclk,    // system clock
    input wire logic aresetn, // sync reset, active low
    srr_cnt_if.cnt c          // load, enable, done
);
    logic [W-1:0] cnt_q;

    // done marks the enable that consumes the last count
    assign c.done = c.en && (cnt_q == W'(1));

    // load wins over counting
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cnt_q <= '0;
        else if (c.load)
            cnt_q <= c.init;
        else if (c.en && cnt_q != '0)
            cnt_q <= cnt_q - W'(1);
    end
endmodule

/* File: core/srr_top.sv */
// stop recovery and debug reset sequencer with AXI4-Lite registers
// assumes core, debug unit and watchdog on aclk; port pins asynchronous
`timescale 1ns/100ps
`include "srr_cfg.svh"
module srr_top #(
    parameter int NPIN = 8,
    parameter int WDO_DIV = `SRR_CLK_HZ / `SRR_WDO_HZ
)
(
    input wire logic aclk,              // 200 MHz system clock
    input wire logic aresetn,           // sync reset, active low
    input wire logic [7:0] awaddr,      // write address
    input wire logic awvalid,           // write address valid
    output logic awready,               // write address ready
    input wire logic [31:0] wdata,      // write data
    input wire logic [3:0] wstrb,       // write strobes
    input wire logic wvalid,            // write data valid
    output logic wready,                // write data ready
    output logic [1:0] bresp,           // write response
    output logic bvalid,                // write response valid
    input wire logic bready,            // write response ready
    input wire logic [7:0] araddr,      // read address
    input wire logic arvalid,           // read address valid
    output logic arready,               // read address ready
    output logic [31:0] rdata,          // read data
    output logic [1:0] rresp,           // read response
    output logic rvalid,                // read data valid
    input wire logic rready,            // read data ready
    input wire logic stop_exec,         // core executed stop, pulse
    input wire logic wdt_timeout,       // watchdog time-out, pulse
    input wire logic wdt_irq_mode,      // watchdog set for interrupt
    input wire logic irq_enabled,       // core accepts interrupts
    input wire logic wdt_irq_ack,       // core took the watchdog irq
    input wire logic [NPIN-1:0] port_pin, // asynchronous port pins
    output logic core_reset,            // core held in reset
    output logic sys_reset,             // peripherals reset, not debug unit
    output logic vec_fetch,             // pulse: fetch reset vector
    output logic [15:0] vec_addr,       // reset vector address
    output logic wdt_irq,               // watchdog irq to core
    output logic [NPIN-1:0] port_in_sample, // port input sample register
    output logic irq                    // block interrupt, level
);
    localparam int DIV_W = $clog2(WDO_DIV + 1);

    logic [DIV_W-1:0] div_q;
    logic wdo_tick_q;
    logic [NPIN-1:0] pin_m_q, pin_s_q, port_in_q, wake_en_q;
    srr_pkg::srr_state_t state_q;
    logic dbg_q, core_reset_q, sys_reset_q, vec_fetch_q, wdt_pend_q, wdt_irq_q;
    logic [15:0] vec_addr_q;
    logic ctrl_rst_q, irq_q;
    logic [2:0] wctl_q, istat_q, imask_q;
    logic aw_have_q, w_have_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q, rdata_q;
    logic [3:0] w_strb_q;
    logic [1:0] bresp_q, rresp_q;
    logic wake_pin, wake_wdt, stop_wake, dbg_go, hold_go, wr_fire, wr_en;
    logic wr_ctrl, wr_wctl, wr_istat, wr_imask, wr_wake, wr_hit;
    logic [31:0] rd_data;
    logic rd_hit;

    srr_cnt_if #(.W(7)) wdo_c ();
    srr_cnt_if #(.W(7)) sys_c ();

    // oscillator tick divider; runs free, not restarted by a hold, so the first phase's first tick may come early
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            div_q <= '0;
            wdo_tick_q <= 1'b0;
        end
        else if (div_q == DIV_W'(WDO_DIV - 1))
        begin
            div_q <= '0;
            wdo_tick_q <= 1'b1;
        end
        else
        begin
            div_q <= div_q + DIV_W'(1);
            wdo_tick_q <= 1'b0;
        end
    end

    // two-stage pin synchroniser
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_m_q <= '0;
            pin_s_q <= '0;
        end
        else
        begin
            pin_m_q <= port_pin;
            pin_s_q <= pin_m_q;
        end
    end

    // wake and start conditions
    assign wake_pin = |((pin_s_q ^ port_in_q) & wake_en_q);
    assign wake_wdt = wdt_timeout;
    assign stop_wake = (state_q == srr_pkg::SRR_STOP) && (wake_pin || wake_wdt);
    assign dbg_go = ctrl_rst_q && (state_q == srr_pkg::SRR_RUN);
    assign hold_go = dbg_go || stop_wake;

    // hold phase counters: oscillator ticks, then system clocks
    assign wdo_c.load = hold_go;
    assign wdo_c.init = `SRR_WDO_CYCLES;
    assign wdo_c.en = (state_q == srr_pkg::SRR_HOLD_WDO) && wdo_tick_q;
    assign sys_c.load = (state_q == srr_pkg::SRR_HOLD_WDO) && wdo_c.done;
    assign sys_c.init = `SRR_SYS_CYCLES;
    assign sys_c.en = (state_q == srr_pkg::SRR_HOLD_SYS);

    srr_cnt #(.W(7)) u_wdo_cnt (.aclk(aclk), .aresetn(aresetn), .c(wdo_c));
    srr_cnt #(.W(7)) u_sys_cnt (.aclk(aclk), .aresetn(aresetn), .c(sys_c));

    // sequencer; stop is entered only from the core's stop instruction
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_q <= srr_pkg::SRR_RUN;
            dbg_q <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                srr_pkg::SRR_RUN:
                    if (dbg_go)
                    begin
                        state_q <= srr_pkg::SRR_HOLD_WDO;
                        dbg_q <= 1'b1;
                    end
                    else if (stop_exec)
                    begin
                        state_q <= srr_pkg::SRR_STOP;
                        dbg_q <= 1'b0;
                    end
                srr_pkg::SRR_STOP:
                    if (stop_wake)
                        state_q <= srr_pkg::SRR_HOLD_WDO;
                srr_pkg::SRR_HOLD_WDO:
                    if (wdo_c.done)
                        state_q <= srr_pkg::SRR_HOLD_SYS;
                srr_pkg::SRR_HOLD_SYS:
                    if (sys_c.done)
                        state_q <= srr_pkg::SRR_RUN;
            endcase
        end
    end

    // reset outputs; stop recovery leaves peripherals and ram alone
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            core_reset_q <= 1'b0;
            sys_reset_q <= 1'b0;
        end
        else if (hold_go)
        begin
            core_reset_q <= 1'b1;
            sys_reset_q <= dbg_go;
        end
        else if (sys_c.done)
        begin
            core_reset_q <= 1'b0;
            sys_reset_q <= 1'b0;
        end
    end

    // vector fetch request on release
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            vec_fetch_q <= 1'b0;
            vec_addr_q <= `SRR_VEC_ADDR;
        end
        else
        begin
            vec_fetch_q <= sys_c.done;
            vec_addr_q <= `SRR_VEC_ADDR;
        end
    end

    // watchdog irq deferred until the core is released
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wdt_pend_q <= 1'b0;
            wdt_irq_q <= 1'b0;
        end
        else
        begin
            if (stop_wake && wake_wdt && wdt_irq_mode && irq_enabled)
                wdt_pend_q <= 1'b1;
            else if (sys_c.done)
                wdt_pend_q <= 1'b0;
            if (sys_c.done && wdt_pend_q)
                wdt_irq_q <= 1'b1;
            else if (wdt_irq_ack)
                wdt_irq_q <= 1'b0;
        end
    end

    // input sampling frozen outside run, so short wake pulses go unrecorded
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            port_in_q <= '0;
        else if (state_q == srr_pkg::SRR_RUN)
            port_in_q <= pin_s_q;
    end

    // register bus decode
    assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
    assign wr_en = wr_fire && w_strb_q[0];
    assign wr_ctrl = wr_en && aw_addr_q == `SRR_OFF_CTRL;
    assign wr_wctl = wr_en && aw_addr_q == `SRR_OFF_WCTL;
    assign wr_istat = wr_en && aw_addr_q == `SRR_OFF_ISTAT;
    assign wr_imask = wr_en && aw_addr_q == `SRR_OFF_IMASK;
    assign wr_wake = wr_en && aw_addr_q == `SRR_OFF_WAKE_EN;
    assign wr_hit = aw_addr_q == `SRR_OFF_CTRL || aw_addr_q == `SRR_OFF_WCTL ||
        aw_addr_q == `SRR_OFF_ISTAT || aw_addr_q == `SRR_OFF_IMASK ||
        aw_addr_q == `SRR_OFF_WAKE_EN || aw_addr_q == `SRR_OFF_PORT_IN ||
        aw_addr_q == `SRR_OFF_STATE;

    // request bit: hardware clears it as the reset starts, a new write wins
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ctrl_rst_q <= 1'b0;
        else if (wr_ctrl)
            ctrl_rst_q <= w_data_q[`SRR_CTRL_RST];
        else if (dbg_go)
            ctrl_rst_q <= 1'b0;
    end

    // watchdog control flags; set wins over write-one-to-clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            wctl_q <= `SRR_WCTL_RST;
        else
        begin
            wctl_q[`SRR_WCTL_POR] <= (wctl_q[`SRR_WCTL_POR] &
                ~(wr_wctl & w_data_q[`SRR_WCTL_POR])) | (sys_c.done & dbg_q);
            wctl_q[`SRR_WCTL_STOP] <= (wctl_q[`SRR_WCTL_STOP] &
                ~(wr_wctl & w_data_q[`SRR_WCTL_STOP])) | stop_wake;
            wctl_q[`SRR_WCTL_WDT] <= (wctl_q[`SRR_WCTL_WDT] &
                ~(wr_wctl & w_data_q[`SRR_WCTL_WDT])) | (stop_wake & wake_wdt);
        end
    end

    // interrupt status, mask and wake enables
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            istat_q <= 3'h0;
            imask_q <= `SRR_IMASK_RST;
            wake_en_q <= {NPIN{`SRR_WAKE_EN_RST}};
            irq_q <= 1'b0;
        end
        else
        begin
            istat_q <= (istat_q & ~({3{wr_istat}} & w_data_q[2:0])) |
                {(state_q == srr_pkg::SRR_RUN) && (pin_s_q != port_in_q),
                 sys_c.done & dbg_q, stop_wake};
            if (wr_imask)
                imask_q <= w_data_q[2:0];
            if (wr_wake)
                wake_en_q <= w_data_q[NPIN-1:0];
            irq_q <= |(istat_q & imask_q);
        end
    end

    // write channels, taken in either order, one write at a time
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end
        else
        begin
            if (awvalid && awready_q)
            begin
                aw_have_q <= 1'b1;
                awready_q <= 1'b0;
                aw_addr_q <= awaddr;
            end
            if (wvalid && wready_q)
            begin
                w_have_q <= 1'b1;
                wready_q <= 1'b0;
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
            if (wr_fire)
            begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? 2'h0 : 2'h2;
            end
            else if (bvalid_q && bready)
            begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    // read mux; unmapped words answer slverr with zero data
    always_comb
    begin
        rd_data = 32'h0000_0000;
        rd_hit = 1'b1;
        unique case (araddr)
            `SRR_OFF_CTRL: rd_data[`SRR_CTRL_RST] = ctrl_rst_q;
            `SRR_OFF_WCTL: rd_data[2:0] = wctl_q;
            `SRR_OFF_ISTAT: rd_data[2:0] = istat_q;
            `SRR_OFF_IMASK: rd_data[2:0] = imask_q;
            `SRR_OFF_WAKE_EN: rd_data[NPIN-1:0] = wake_en_q;
            `SRR_OFF_PORT_IN: rd_data[NPIN-1:0] = port_in_q;
            `SRR_OFF_STATE: rd_data[1:0] = state_q;
            default: rd_hit = 1'b0;
        endcase
    end

    // read channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= 2'h0;
        end
        else if (arvalid && arready_q)
        begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_data;
            rresp_q <= rd_hit ? 2'h0 : 2'h2;
        end
        else if (rvalid_q && rready)
        begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign core_reset = core_reset_q;
    assign sys_reset = sys_reset_q;
    assign vec_fetch = vec_fetch_q;
    assign vec_addr = vec_addr_q;
    assign wdt_irq = wdt_irq_q;
    assign port_in_sample = port_in_q;
    assign irq = irq_q;

    // helper counters over each hold phase, read only by checks
    logic [7:0] chk_tick_q, chk_sys_q;
    always_ff @(posedge aclk)
    begin
        if (!aresetn || hold_go)
        begin
            chk_tick_q <= 8'h00;
            chk_sys_q <= 8'h00;
        end
        else
        begin
            if (state_q == srr_pkg::SRR_HOLD_WDO && wdo_tick_q)
                chk_tick_q <= chk_tick_q + 8'h01;
            if (state_q == srr_pkg::SRR_HOLD_SYS)
                chk_sys_q <= chk_sys_q + 8'h01;
        end
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_dbg_start;
        dbg_go |=> core_reset_q && sys_reset_q && state_q == srr_pkg::SRR_HOLD_WDO;
    endproperty
    a_dbg_start: assert property (p_dbg_start) else $error("debug reset not started");
    property p_rst_clear;
        (dbg_go && !wr_ctrl) |=> !ctrl_rst_q;
    endproperty
    a_rst_clear: assert property (p_rst_clear) else $error("request bit not cleared");
    property p_por_flag;
        (sys_c.done && dbg_q) |=> wctl_q[`SRR_WCTL_POR] && !core_reset_q;
    endproperty
    a_por_flag: assert property (p_por_flag) else $error("por flag missing");
    property p_wdo_phase;
        $rose(state_q == srr_pkg::SRR_HOLD_SYS) |-> chk_tick_q == 8'h42;
    endproperty
    a_wdo_phase: assert property (p_wdo_phase) else $error("oscillator phase length wrong");
    property p_sys_phase;
        $fell(core_reset_q) |-> chk_sys_q == 8'h10;
    endproperty
    a_sys_phase: assert property (p_sys_phase) else $error("clock phase length wrong");
    property p_stop_keep;
        (core_reset_q && !dbg_q) |-> !sys_reset_q;
    endproperty
    a_stop_keep: assert property (p_stop_keep) else $error("stop recovery reset peripherals");
    property p_vector;
        $fell(core_reset_q) |-> vec_fetch_q && vec_addr_q == 16'h0002;
    endproperty
    a_vector: assert property (p_vector) else $error("vector fetch missing");
    property p_stop_flag;
        stop_wake |=> wctl_q[`SRR_WCTL_STOP] && core_reset_q;
    endproperty
    a_stop_flag: assert property (p_stop_flag) else $error("stop flag missing");
    property p_wdt_flags;
        (stop_wake && wake_wdt) |=> wctl_q[`SRR_WCTL_WDT] && wctl_q[`SRR_WCTL_STOP];
    endproperty
    a_wdt_flags: assert property (p_wdt_flags) else $error("watchdog flags missing");
    property p_wdt_irq;
        ($fell(core_reset_q) && $past(wdt_pend_q)) |-> wdt_irq_q;
    endproperty
    a_wdt_irq: assert property (p_wdt_irq) else $error("watchdog irq not raised");
    property p_pin_wake;
        (state_q == srr_pkg::SRR_STOP && wake_pin) |=> state_q == srr_pkg::SRR_HOLD_WDO;
    endproperty
    a_pin_wake: assert property (p_pin_wake) else $error("pin change did not wake");
    property p_no_sample;
        (state_q != srr_pkg::SRR_RUN) |=> $stable(port_in_q);
    endproperty
    a_no_sample: assert property (p_no_sample) else $error("sample taken in stop");
endmodule

/* File: verif/srr_core_model.sv */
// behavioural core and watchdog facing the reset sequencer
// assumes the bench commands stop and watchdog events as one-cycle pulses
`timescale 1ns/100ps
module srr_core_model
(
    input wire logic aclk,     // system clock
    input wire logic aresetn,  // sync reset, active low
    input wire logic cmd_stop, // bench: execute stop
    input wire logic cmd_wdt,  // bench: watchdog expires
    input wire logic wdt_irq,  // watchdog irq from block
    output logic stop_exec,    // stop executed, pulse
    output logic wdt_timeout,  // time-out pulse
    output logic wdt_irq_ack   // irq taken, pulse
);
    logic [1:0] ack_cnt_q;

    // stop only when told, irq answered slowly to stretch the level
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            stop_exec <= 1'b0;
            wdt_timeout <= 1'b0;
            ack_cnt_q <= 2'h0;
            wdt_irq_ack <= 1'b0;
        end
        else
        begin
            stop_exec <= cmd_stop;
            wdt_timeout <= cmd_wdt;
            ack_cnt_q <= wdt_irq ? ack_cnt_q + 2'h1 : 2'h0;
            wdt_irq_ack <= (ack_cnt_q == 2'h2);
        end
    end
endmodule

/* File: verif/testbench.sv */
// bench for the stop recovery and debug reset sequencer
// assumes the register offsets and fields of the design's header
`timescale 1ns/100ps
`include "srr_cfg.svh"
module testbench;
    localparam int DIV = 4;
    localparam int LO = 65 * DIV + 17;
    localparam int HI = 66 * DIV + 16;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
    logic arready, rvalid, core_reset, sys_reset, vec_fetch, wdt_irq, irq, fetch_seen;
    logic stop_exec, wdt_timeout, wdt_irq_ack, cmd_stop, cmd_wdt, wdt_irq_mode, irq_enabled;
    logic [7:0] awaddr, araddr, port_pin, port_in_sample;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp, r;
    logic [3:0] wstrb;
    logic [15:0] vec_addr;
    int error_cnt, comparisons, cyc, run_n, last_n;

    srr_top #(.NPIN(8), .WDO_DIV(DIV)) dut_u (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .stop_exec(stop_exec), .wdt_timeout(wdt_timeout),
        .wdt_irq_mode(wdt_irq_mode), .irq_enabled(irq_enabled), .wdt_irq_ack(wdt_irq_ack),
        .port_pin(port_pin), .core_reset(core_reset), .sys_reset(sys_reset),
        .vec_fetch(vec_fetch), .vec_addr(vec_addr), .wdt_irq(wdt_irq),
        .port_in_sample(port_in_sample), .irq(irq));
    srr_core_model core_u (.aclk(aclk), .aresetn(aresetn), .cmd_stop(cmd_stop),
        .cmd_wdt(cmd_wdt), .wdt_irq(wdt_irq), .stop_exec(stop_exec),
        .wdt_timeout(wdt_timeout), .wdt_irq_ack(wdt_irq_ack));

    initial
    begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    // hold length and vector fetch seen at the falling edge of core reset
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 6000)
        begin
            error_cnt++;
            conclude();
        end
        if (core_reset === 1'b1)
            run_n <= run_n + 1;
        else
        begin
            if (run_n != 0)
                last_n <= run_n;
            if (run_n != 0)
                fetch_seen <= vec_fetch;
            run_n <= 0;
        end
    end

    task automatic conclude();
        if (error_cnt == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            error_cnt++;
            $display("BAD %s exp %0h got %0h", nm, e, g);
        end
    endtask

    // each channel released at its own handshake; no latency assumed
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", 2'b00, bresp);
    endtask

    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        rready <= 1'b0;
        d = rdata;
        r = rresp;
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk("rresp", 2'b00, r);
        chk(nm, e, d);
    endtask

    task automatic pulse(input logic stp);
        if (stp)
            cmd_stop <= 1'b1;
        else
            cmd_wdt <= 1'b1;
        @(posedge aclk);
        cmd_stop <= 1'b0;
        cmd_wdt <= 1'b0;
        repeat (4) @(posedge aclk);
    endtask

    // wait for a whole reset hold, then judge its length and the fetch
    task automatic wait_rel(input logic exp_sys);
        while (core_reset !== 1'b1)
            @(posedge aclk);
        chk("sys_reset", exp_sys, sys_reset);
        while (core_reset !== 1'b0)
            @(posedge aclk);
        @(posedge aclk);
        chk("hold_in_range", 1, last_n >= LO && last_n <= HI);
        chk("vec_fetch", 1, fetch_seen);
        chk("vec_addr", 16'h0002, vec_addr);
    endtask

    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, cmd_stop, cmd_wdt} = 8'h00;
        {wdt_irq_mode, irq_enabled, awaddr, araddr, port_pin, wdata} = 0;
        wstrb = 4'hF;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rchk("wctl", `SRR_OFF_WCTL, 0);
        rchk("state", `SRR_OFF_STATE, 0);
        rd(8'h1C);
        chk("unmapped_resp", 2'b10, r);
        // debug reset: request clears itself, only the debug unit survives
        wr(`SRR_OFF_CTRL, 1);
        rchk("ctrl", `SRR_OFF_CTRL, 0);
        wait_rel(1'b1);
        rchk("wctl", `SRR_OFF_WCTL, 1);
        wr(`SRR_OFF_WCTL, 7);
        wr(`SRR_OFF_WAKE_EN, 8'h08);
        // watchdog wake with irq pending; pins change while stopped
        wdt_irq_mode <= 1'b1;
        irq_enabled <= 1'b1;
        pulse(1'b1);
        rchk("state", `SRR_OFF_STATE, 1);
        port_pin <= 8'h81;
        repeat (6) @(posedge aclk);
        chk("sample_frozen", 0, port_in_sample);
        pulse(1'b0);
        wait_rel(1'b0);
        chk("wdt_irq", 1, wdt_irq);
        repeat (8) @(posedge aclk);
        chk("wdt_irq_acked", 0, wdt_irq);
        chk("sample_held", 8'h81, port_in_sample);
        rchk("wctl", `SRR_OFF_WCTL, 6);
        // a write with lane 0 off must leave the enables alone
        wstrb <= 4'h0;
        wr(`SRR_OFF_WAKE_EN, 8'hFF);
        wstrb <= 4'hF;
        rchk("wake_en", `SRR_OFF_WAKE_EN, 8'h08);
        chk("irq_masked", 0, irq);
        rchk("istat", `SRR_OFF_ISTAT, 7);
        wr(`SRR_OFF_IMASK, 1);
        repeat (2) @(posedge aclk);
        chk("irq", 1, irq);
        wr(`SRR_OFF_ISTAT, 7);
        repeat (2) @(posedge aclk);
        chk("irq_cleared", 0, irq);
        wr(`SRR_OFF_WCTL, 7);
        // short rising pulse on an enabled pin wakes but is not recorded
        wdt_irq_mode <= 1'b0;
        pulse(1'b1);
        port_pin <= 8'h89;
        repeat (3) @(posedge aclk);
        port_pin <= 8'h81;
        wait_rel(1'b0);
        chk("pulse_not_kept", 8'h81, port_in_sample);
        chk("no_wdt_irq", 0, wdt_irq);
        chk("irq_wake", 1, irq);
        rchk("wctl", `SRR_OFF_WCTL, 2);
        // falling level held through the hold is recorded
        port_pin <= 8'h89;
        repeat (6) @(posedge aclk);
        pulse(1'b1);
        port_pin <= 8'h81;
        wait_rel(1'b0);
        repeat (4) @(posedge aclk);
        chk("fall_kept", 8'h81, port_in_sample);
        conclude();
    end
endmodule
